// ---- verilog/tis_tail.sv ----
/*
 * tis_tail: shift, exit, pause and update states of the instruction scan.
 * assumes: entry from outside via enter_exit1 / enter_shift pulses;
 *          the tester keeps tck well below a quarter of clk.
 */
`timescale 1ns/10ps
// Behaviour
// R01 - pause holds, no shifting, while select is low at test-clock rise
// R02 - pause goes to second exit on rise with select high
// R03 - second exit with select high goes to update
// R04 - second exit with select low returns to shift
// R05 - update copies shift register to output on test-clock fall
// R06 - latched instruction becomes the active instruction
// R07 - pause and second exit leave instruction unchanged
// R08 - update keeps data registers; only instruction output changes
// R09 - first exit with select low enters pause
// R10 - shift state moves register one stage per rise, tdi in, tdo out
// R11 - instruction output stable outside update
module tis_tail (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// test pins
	input  wire logic                      tck,
	input  wire logic                      tms,
	input  wire logic                      tdi,
	output logic                           tdo,
	// joins with the rest of the controller
	input  wire logic                      enter_exit1,
	input  wire logic                      enter_shift,
	output logic                           in_tail,
	output logic                           update_done,
	output logic [tis_pkg::IR_W-1:0]       instr,
	output logic                           dr_hold
);
	tis_edge_if ei ();

	tis_sync u_sync (
		.clk (clk),
		.rst (rst),
		.tck (tck),
		.tms (tms),
		.tdi (tdi),
		.eo  (ei.src)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	tis_pkg::tis_state_e          st_q, st_d;
	logic                         rise_act;

	// an entry pulse wins over a test-clock rise seen in the same cycle
	assign rise_act = ei.rise & ~enter_shift & ~enter_exit1;

	always_comb begin
		st_d = st_q;
		if (enter_shift) begin
			st_d = tis_pkg::ST_SHIFT;
		end else if (enter_exit1) begin
			st_d = tis_pkg::ST_EXIT1;
		end else if (ei.rise) begin
			case (st_q)
				tis_pkg::ST_SHIFT: begin
					st_d = ei.tms ? tis_pkg::ST_EXIT1 : tis_pkg::ST_SHIFT;  // see R10
				end
				tis_pkg::ST_EXIT1: begin
					st_d = ei.tms ? tis_pkg::ST_UPDATE : tis_pkg::ST_PAUSE;  // see R09
				end
				tis_pkg::ST_PAUSE: begin
					st_d = ei.tms ? tis_pkg::ST_EXIT2 : tis_pkg::ST_PAUSE;  // see R01 see R02
				end
				tis_pkg::ST_EXIT2: begin
					st_d = ei.tms ? tis_pkg::ST_UPDATE : tis_pkg::ST_SHIFT;  // see R03 see R04
				end
				tis_pkg::ST_UPDATE: begin
					st_d = tis_pkg::ST_IDLE;
				end
				default: begin
					st_d = st_q;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= tis_pkg::ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// instruction shift register and serial out
	// ----------------------------------------------------------------
	logic [tis_pkg::IR_W-1:0]     sr_q, sr_d;
	logic                         tdo_q, tdo_d;

	// only the shift state moves the register, so pause and exits keep it
	always_comb begin
		sr_d  = sr_q;
		tdo_d = tdo_q;
		if (rise_act && st_q == tis_pkg::ST_SHIFT) begin
			sr_d  = {ei.tdi, sr_q[tis_pkg::IR_W-1:1]};  // see R10
			tdo_d = sr_q[0];                            // see R10
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sr_q  <= tis_pkg::IR_RESET_VAL;
			tdo_q <= 1'h0;
		end else begin
			sr_q  <= sr_d;
			tdo_q <= tdo_d;
		end
	end

	// ----------------------------------------------------------------
	// active instruction
	// ----------------------------------------------------------------
	logic [tis_pkg::IR_W-1:0]     ir_q, ir_d;
	logic                         upd_q, upd_d;

	// new instruction only on the falling edge inside update; the rising
	// edge there already leaves for idle, so it could not be used instead
	always_comb begin
		ir_d  = ir_q;
		upd_d = 1'h0;
		if (ei.fall && st_q == tis_pkg::ST_UPDATE) begin
			ir_d  = sr_q;  // see R05 see R06 see R11
			upd_d = 1'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ir_q  <= tis_pkg::IR_RESET_VAL;
			upd_q <= 1'h0;
		end else begin
			ir_q  <= ir_d;
			upd_q <= upd_d;
		end
	end

	assign tdo         = tdo_q;
	assign instr       = ir_q;
	assign update_done = upd_q;
	assign in_tail     = (st_q != tis_pkg::ST_IDLE);
	// data registers frozen throughout the tail, update included
	assign dr_hold     = in_tail;  // see R07 see R08

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_pause_stays: assert property (  // see R01
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_PAUSE && rise_act && !ei.tms)
		|=> st_q == tis_pkg::ST_PAUSE && $stable(sr_q)) else $error("pause left");
	a_pause_exit: assert property (  // see R02
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_PAUSE && rise_act && ei.tms)
		|=> st_q == tis_pkg::ST_EXIT2) else $error("pause exit wrong");
	a_exit2_update: assert property (  // see R03
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_EXIT2 && rise_act && ei.tms)
		|=> st_q == tis_pkg::ST_UPDATE) else $error("exit2 no update");
	a_exit2_shift: assert property (  // see R04
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_EXIT2 && rise_act && !ei.tms)
		|=> st_q == tis_pkg::ST_SHIFT) else $error("exit2 no shift");
	a_update_fall: assert property (  // see R05
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_UPDATE && ei.fall) |=> ir_q == $past(sr_q) && upd_q)
		else $error("update missed");
	a_instr_stable: assert property (  // see R11
		@(posedge clk) disable iff (rst)
		!(st_q == tis_pkg::ST_UPDATE && ei.fall) |=> $stable(ir_q))
		else $error("instr moved");
	a_exit1_pause: assert property (  // see R09
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_EXIT1 && rise_act && !ei.tms)
		|=> st_q == tis_pkg::ST_PAUSE) else $error("exit1 no pause");
	a_shift_step: assert property (  // see R10
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_SHIFT && rise_act)
		|=> sr_q[tis_pkg::IR_W-1] == $past(ei.tdi) && tdo_q == $past(sr_q[0]))
		else $error("shift step wrong");
	a_dr_frozen: assert property (  // see R07
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_PAUSE || st_q == tis_pkg::ST_EXIT2
		|| st_q == tis_pkg::ST_UPDATE) |-> dr_hold) else $error("dr not held");
	a_shift_stay: assert property (  // see R10
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_SHIFT && rise_act && !ei.tms)
		|=> st_q == tis_pkg::ST_SHIFT) else $error("shift left early");
	a_shift_leave: assert property (  // see R10
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_SHIFT && rise_act && ei.tms)
		|=> st_q == tis_pkg::ST_EXIT1) else $error("shift no exit1");
	a_exit1_update: assert property (  // see R09
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_EXIT1 && rise_act && ei.tms)
		|=> st_q == tis_pkg::ST_UPDATE) else $error("exit1 no update");
	a_update_idle: assert property (  // see R03
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_UPDATE && rise_act)
		|=> st_q == tis_pkg::ST_IDLE) else $error("update no idle");
	a_enter_shift: assert property (  // see R10
		@(posedge clk) disable iff (rst)
		enter_shift |=> st_q == tis_pkg::ST_SHIFT)
		else $error("entry to shift lost");
	a_enter_exit1: assert property (  // see R09
		@(posedge clk) disable iff (rst)
		(enter_exit1 && !enter_shift) |=> st_q == tis_pkg::ST_EXIT1)
		else $error("entry to exit1 lost");
	a_sr_only_shift: assert property (  // see R01
		@(posedge clk) disable iff (rst)
		!(st_q == tis_pkg::ST_SHIFT && rise_act) |=> $stable(sr_q))
		else $error("shift outside shift state");
	a_tdo_held: assert property (  // see R10
		@(posedge clk) disable iff (rst)
		!(st_q == tis_pkg::ST_SHIFT && rise_act) |=> $stable(tdo_q))
		else $error("tdo moved");
	a_upd_cause: assert property (  // see R06
		@(posedge clk) disable iff (rst)
		!(st_q == tis_pkg::ST_UPDATE && ei.fall) |=> !upd_q)
		else $error("stray update pulse");
	a_tail_instr: assert property (  // see R07
		@(posedge clk) disable iff (rst)
		(st_q == tis_pkg::ST_PAUSE || st_q == tis_pkg::ST_EXIT2) |=> $stable(ir_q))
		else $error("instr moved in pause or exit2");
	a_update_sr_kept: assert property (  // see R08
		@(posedge clk) disable iff (rst)
		st_q == tis_pkg::ST_UPDATE |=> $stable(sr_q))
		else $error("shift register moved in update");
endmodule

// ---- verilog/tis_pkg.sv ----
/*
 * tis_pkg: shared constants for the instruction-register scan tail.
 * assumes: one system clock at 200 MHz, link pins sampled by that clock.
 */
package tis_pkg;
	// ----------------------------------------------------------------
	// widths and values
	// ----------------------------------------------------------------
	localparam int unsigned IR_W         = 3;
	localparam logic [2:0]  IR_RESET_VAL = 3'h0;
	localparam int unsigned SYNC_W       = 2;

	// ----------------------------------------------------------------
	// scan-tail states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXIT1,
		ST_SHIFT,
		ST_PAUSE,
		ST_EXIT2,
		ST_UPDATE
	} tis_state_e;
endpackage

// ---- verilog/tis_edge_if.sv ----
/*
 * tis_edge_if: synchronised test-clock edge strobes and select level.
 * assumes: driven by tis_sync, read by the scan tail on the same clock.
 */
`timescale 1ns/10ps
interface tis_edge_if;
	logic rise;
	logic fall;
	logic tms;
	logic tdi;
	modport src (output rise, output fall, output tms, output tdi);
	modport dst (input rise, input fall, input tms, input tdi);
endinterface

// ---- verilog/tis_sync.sv ----
/*
 * tis_sync: two-flop synchronisers for the test pins and edge detection.
 * assumes: pins are asynchronous to clk and much slower than it.
 */
`timescale 1ns/10ps
module tis_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// raw pins
	input  wire logic tck,
	input  wire logic tms,
	input  wire logic tdi,
	// strobes out
	tis_edge_if.src   eo
);
	logic [2:0] s1_q, s1_d;
	logic [2:0] s2_q, s2_d;
	logic       ck_q, ck_d;

	always_comb begin
		s1_d = {tck, tms, tdi};
		s2_d = s1_q;
		ck_d = s2_q[2];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			ck_q <= 1'h0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			ck_q <= ck_d;
		end
	end

	// edges compare the second stage with its delayed copy in ck_q
	assign eo.rise = s2_q[2] & ~ck_q;
	assign eo.fall = ~s2_q[2] & ck_q;
	assign eo.tms  = s2_q[1];
	assign eo.tdi  = s2_q[0];
endmodule

// ---- verif/tis_tester.sv ----
/*
 * tis_tester: behavioural test controller driving tck, tms and tdi.
 * assumes: 125 ns test clock; tck rests low between frames;
 *          tasks are called 1 ns after a clk rise.
 */
`timescale 1ns/10ps
module tis_tester (
	// test pins
	output logic tck,
	output logic tms,
	output logic tdi
);
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
	end
	// every delay is whole clk periods, so pins always move 1 ns after a clk rise
	// select and data set up well before the rise
	task automatic rise(input logic s, input logic d);
		tms = s;
		tdi = d;
		#30;
		tck = 1'h1;
		#30;
	endtask
	// data is stale after the fall, so it flips rather than lingering
	task automatic fall();
		#30;
		tck = 1'h0;
		tdi = ~tdi;
		#35;
	endtask
	task automatic step(input logic s, input logic d);
		rise(s, d);
		fall();
	endtask
endmodule

// ---- verif/test_tis_tail.sv ----
/*
 * test_tis_tail: self-checking bench for the instruction scan tail.
 * assumes: tis_tester drives the pins; entry pulses come from here.
 */
`timescale 1ns/10ps
module test_tis_tail;
	logic       clk;
	logic       rst;
	logic       tck;
	logic       tms;
	logic       tdi;
	logic       tdo;
	logic       enter_exit1;
	logic       enter_shift;
	logic       in_tail;
	logic       update_done;
	logic       dr_hold;
	logic [2:0] instr;
	logic [2:0] cur;
	int         fail_count;
	int         tests_run;
	int         cycles;
	int         pulses;

	tis_tester PTN (.tck(tck), .tms(tms), .tdi(tdi));
	tis_tail DUT (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.enter_exit1(enter_exit1), .enter_shift(enter_shift), .in_tail(in_tail),
		.update_done(update_done), .instr(instr), .dr_hold(dr_hold));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// hang guard well above the under a thousand cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (update_done === 1'b1) begin
			pulses <= pulses + 1;
		end
		if (cycles == 8000) begin
			$display("Error timeout expected finish seen hang");
			fail_count++;
			final_report();
		end
	end

	task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic go(input logic to_shift);
		@(posedge clk);
		#1;
		enter_shift = to_shift;
		enter_exit1 = ~to_shift;
		@(posedge clk);
		#1;
		enter_shift = 1'b0;
		enter_exit1 = 1'b0;
	endtask

	// first bit in ends as lsb; third rise leaves for exit1
	task automatic shift_word(input logic [2:0] v, input logic [2:0] old, input logic chk);
		for (int i = 0; i < 3; i++) begin
			PTN.rise(i == 2, v[i]);
			if (chk) check("tdo", {2'h0, old[i]}, {2'h0, tdo});
			check("instr", cur, instr);
			PTN.fall();
		end
	endtask

	// exit1 -> pause (held) -> exit2 -> update -> idle
	task automatic finish(input logic [2:0] v);
		int n;
		n = pulses;
		PTN.step(1'b0, 1'b0);
		PTN.step(1'b0, 1'b1);
		check("in_tail", 3'h1, {2'h0, in_tail});
		PTN.step(1'b1, 1'b0);
		check("instr", cur, instr);
		PTN.rise(1'b1, 1'b0);
		check("instr", cur, instr);
		check("dr_hold", 3'h1, {2'h0, dr_hold});
		PTN.fall();
		check("instr", v, instr);
		check("update_done", 3'h1, 3'(pulses - n));
		PTN.step(1'b0, 1'b0);
		check("in_tail", 3'h0, {2'h0, in_tail});
		cur = v;
	endtask

	task automatic scan_plain(input logic [2:0] v);
		go(1'b1);
		shift_word(v, 3'h0, 1'b0);
		finish(v);
	endtask

	task automatic scan_resume(input logic [2:0] a, input logic [2:0] b);
		go(1'b1);
		shift_word(a, 3'h0, 1'b0);
		PTN.step(1'b0, 1'b0);
		PTN.step(1'b1, 1'b0);
		PTN.step(1'b0, 1'b1);
		shift_word(b, a, 1'b1);
		finish(b);
	endtask

	// idle ignores the pins; then two bits go in (lsb first, in at msb)
	// and the part-shifted word is forced out through exit1
	task automatic scan_from_exit1();
		PTN.step(1'b1, 1'b0);
		check("in_tail", 3'h0, {2'h0, in_tail});
		check("instr", cur, instr);
		go(1'b1);
		PTN.step(1'b0, 1'b0);
		PTN.step(1'b0, 1'b1);
		go(1'b0);
		finish(3'h4);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		enter_exit1 = 1'b0;
		enter_shift = 1'b0;
		cur = 3'h0;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		check("instr", 3'h0, instr);
		scan_plain(3'h5);
		scan_resume(3'h6, 3'h3);
		scan_from_exit1();
		final_report();
	end
endmodule
